// ### flash_status_cmd.sv
// serial programming front end: matching, status command, permissions
`timescale 1ns/1ps
module flash_status_cmd
  import flash_status_pkg::*;
#(
  parameter int CW = SAMPLES_W
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       rxd_i,
  input  wire logic       erase_password_check_flag_i,
  input  wire logic       debug_security_check_flag_i,
  input  wire logic       security_enabled_flag_i,
  input  wire logic       reserved_area_erased_i,
  output logic            txd_o,
  output logic            idle_o,
  output logic            cmd_start_o,
  output logic [7:0]      cmd_code_o,
  output logic            cmd_needs_password_o,
  output logic [7:0]      status_code_o
);
  typedef enum {P_MATCH1, P_MATCH2, P_CMD, P_REPLY, P_ERR, P_HALT,
                P_BUSY} proto_state_t;
  proto_state_t   state;
  logic           locked;
  logic [CW-1:0]  bit_time;
  logic           rx_valid;
  logic [7:0]     rx_byte;
  logic           tx_busy;
  logic           tx_go;
  logic [7:0]     tx_data;
  logic [CW-1:0]  tx_cnt;
  logic [3:0]     tx_bit;
  logic [9:0]     tx_shift;
  logic [7:0]     reply_idx;
  logic [2:0]     err_cnt;
  logic           halt_after;
  logic [1:0]     f_sync0;
  logic [1:0]     f_sync1;
  logic [1:0]     f_sync2;
  logic [1:0]     f_sync3;
  logic [7:0]     status;
  logic [7:0]     checksum;
  logic [7:0]     next_reply;
  perm_t          perm;
  logic           known;

  uart_byte_rx #(.CW(CW)) u_rx (
    .clk_i        (clk_i),
    .rst_n_i      (rst_n_i),
    .rxd_i        (rxd_i),
    .locked_o     (locked),
    .bit_time_o   (bit_time),
    .byte_valid_o (rx_valid),
    .byte_o       (rx_byte)
  );

  // ******************************************************************
  // flag synchronisers and status byte
  // ******************************************************************
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      f_sync0 <= 2'h0;
      f_sync1 <= 2'h0;
      f_sync2 <= 2'h0;
      f_sync3 <= 2'h0;
    end else begin
      f_sync0 <= {f_sync0[0], erase_password_check_flag_i};
      f_sync1 <= {f_sync1[0], debug_security_check_flag_i};
      f_sync2 <= {f_sync2[0], security_enabled_flag_i};
      f_sync3 <= {f_sync3[0], reserved_area_erased_i};
    end
  end

  always_comb begin
    status = 8'h00;
    status[BIT_ERASE_PW] = f_sync0[1];
    status[BIT_DEBUG_SC] = f_sync1[1];
    status[BIT_SEC]   = f_sync2[1];
    status[BIT_BLANK] = ~f_sync3[1];
  end

  assign checksum = 8'h00 - (status & STATUS_MASK) - RESERVED_VAL;

  // ******************************************************************
  // permission decode
  // ******************************************************************
  always_comb begin
    perm  = PERM_DENY;
    known = 1'b1;
    case (rx_byte)
      CMD_STATUS, CMD_SUM, CMD_PRODUCT: perm = PERM_OK;
      CMD_WRITE, CMD_READ, CMD_LOADER: begin
        if (status[BIT_SEC]) perm = PERM_DENY;
        else if (status[BIT_BLANK]) perm = PERM_PASS;
        else perm = PERM_OK;
      end
      CMD_ERASE: begin
        // chip erase password on string check while the reserved area is not erased
        if (status[BIT_BLANK] && status[BIT_ERASE_PW]) perm = PERM_PASS;
        else perm = PERM_OK;
      end
      CMD_SECURITY: begin
        perm = status[BIT_BLANK] ? PERM_PASS : PERM_DENY;
      end
      default: known = 1'b0;
    endcase
  end

  always_comb begin
    case (reply_idx)
      8'h00:   next_reply = START_MARK;
      8'h01:   next_reply = BYTE_COUNT;
      8'h02:   next_reply = status & STATUS_MASK;
      8'h03:   next_reply = RESERVED_VAL;
      8'h04:   next_reply = RESERVED_VAL;
      8'h05:   next_reply = RESERVED_VAL;
      default: next_reply = checksum;
    endcase
  end

  // ******************************************************************
  // transmitter at the adjusted rate
  // ******************************************************************
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tx_busy  <= 1'b0;
      tx_cnt   <= '0;
      tx_bit   <= 4'h0;
      tx_shift <= 10'h3FF;
      txd_o    <= 1'b1;
    end else if (tx_go && !tx_busy) begin
      tx_busy  <= 1'b1;
      tx_cnt   <= '0;
      tx_bit   <= 4'h0;
      tx_shift <= {1'b1, tx_data, 1'b0};
      txd_o    <= 1'b0;
    end else if (tx_busy) begin
      tx_cnt <= tx_cnt + 1'b1;
      if (tx_cnt == bit_time - 1'b1) begin
        tx_cnt <= '0;
        tx_bit <= tx_bit + 1'b1;
        if (tx_bit == 4'h9) begin
          tx_busy <= 1'b0;
          txd_o   <= 1'b1;
        end else begin
          txd_o    <= tx_shift[1];
          tx_shift <= {1'b1, tx_shift[9:1]};
        end
      end
    end
  end

  // ******************************************************************
  // protocol sequencer
  // ******************************************************************
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state                <= P_MATCH1;
      tx_go                <= 1'b0;
      tx_data              <= 8'h00;
      reply_idx            <= 8'h00;
      err_cnt              <= 3'h0;
      halt_after           <= 1'b0;
      idle_o               <= 1'b0;
      cmd_start_o          <= 1'b0;
      cmd_code_o           <= 8'h00;
      cmd_needs_password_o <= 1'b0;
      status_code_o        <= 8'h00;
    end else begin
      tx_go         <= 1'b0;
      cmd_start_o   <= 1'b0;
      status_code_o <= status & STATUS_MASK;
      case (state)
        P_MATCH1: begin
          // receiver measured rate; echo the match byte
          if (locked && rx_valid && rx_byte == MATCH1_A && !tx_busy) begin
            tx_data <= MATCH1_A;
            tx_go   <= 1'b1;
            state   <= P_MATCH2;
          end
        end
        P_MATCH2: begin
          if (rx_valid && (rx_byte == MATCH2_A || rx_byte == MATCH2_B)) begin
            tx_data <= rx_byte;
            tx_go   <= 1'b1;
            state   <= P_CMD;
          end
        end
        P_CMD: begin
          if (rx_valid) begin
            if (!known) begin
              tx_data <= ERR_CODE_C;
              err_cnt <= 3'h0;
              state   <= P_ERR;
            end else begin
              tx_data    <= rx_byte;
              tx_go      <= 1'b1;
              cmd_code_o <= rx_byte;
              if (perm == PERM_DENY) begin
                state <= P_HALT;
              end else if (rx_byte == CMD_STATUS) begin
                reply_idx <= 8'h00;
                state     <= P_REPLY;
              end else begin
                cmd_start_o          <= 1'b1;
                cmd_needs_password_o <= (perm == PERM_PASS);
                state                <= P_BUSY;
              end
            end
          end
        end
        P_REPLY: begin
          if (!tx_busy && !tx_go) begin
            tx_data   <= next_reply;
            tx_go     <= 1'b1;
            reply_idx <= reply_idx + 8'h01;
            // back to command wait after checksum
            if (reply_idx == LAST_REPLY) state <= P_CMD;
          end
        end
        P_ERR: begin
          if (!tx_busy && !tx_go) begin
            if (err_cnt == ERR_REPEAT) begin
              state <= P_HALT;
            end else begin
              tx_go   <= 1'b1;
              err_cnt <= err_cnt + 3'h1;
            end
          end
        end
        P_BUSY: begin
          // other command bodies live elsewhere; resume on next byte
          if (!tx_busy && !tx_go) state <= P_CMD;
        end
        P_HALT: begin
          if (!tx_busy && !tx_go) idle_o <= 1'b1;
        end
        default: state <= P_HALT;
      endcase
    end
  end

  a_idle_sticky: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    idle_o |=> idle_o) else $error("idle dropped without reset");
  a_idle_silent: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    idle_o |-> !tx_go) else $error("transmit while idle");
  a_blank_bit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $past(rst_n_i) |-> status_code_o[0] == $past(~f_sync3[1]))
    else $error("blank bit wrong");
  a_status_range: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    status_code_o[7:4] == 4'h0) else $error("status out of range");
  a_sum_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    8'(checksum + (status & STATUS_MASK)) == 8'h00)
    else $error("checksum wrong");
  a_write_block: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state == P_CMD && rx_valid && rx_byte == CMD_WRITE && status[BIT_SEC])
    |=> state == P_HALT) else $error("secured write allowed");
  a_status_ok: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state == P_CMD && rx_valid && rx_byte == CMD_STATUS)
    |=> state == P_REPLY && tx_go) else $error("status refused");
  a_err_code: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state == P_CMD && rx_valid && !known) |=> tx_data == ERR_CODE_C)
    else $error("wrong error code");
endmodule

// ### flash_status_cmd_tb_top.sv
// testbench for the serial status command interpreter
`timescale 1ns/1ps
module flash_status_cmd_tb_top
  import flash_status_pkg::*;
;
  localparam int BT = 16;
  logic       clk, rst_n, rxd, erase_pw, debug_sc, sec, erased;
  logic       txd, idle, cmd_start, need_pw, got_start, got_pw;
  logic [7:0] cmd_code, status_code, got_code;
  int         bad_count, check_count;
  logic [7:0] cmds [7] = '{CMD_SUM, CMD_PRODUCT, CMD_WRITE, CMD_READ,
                           CMD_LOADER, CMD_ERASE, CMD_SECURITY};
  // flag sets as {sec, erased, erase_pw}
  logic [2:0] fls [6] = '{3'h2, 3'h6, 3'h0, 3'h1, 3'h5, 3'h4};

  initial clk = 1'b0;
  always #4 clk = ~clk;

  flash_status_cmd u_flash_status_cmd (
    .clk_i                       (clk),
    .rst_n_i                     (rst_n),
    .rxd_i                       (rxd),
    .erase_password_check_flag_i (erase_pw),
    .debug_security_check_flag_i (debug_sc),
    .security_enabled_flag_i     (sec),
    .reserved_area_erased_i      (erased),
    .txd_o                       (txd),
    .idle_o                      (idle),
    .cmd_start_o                 (cmd_start),
    .cmd_code_o                  (cmd_code),
    .cmd_needs_password_o        (need_pw),
    .status_code_o               (status_code)
  );

  prog_ctrl_model #(.BT(BT)) u_prog_ctrl_model (
    .clk_i (clk),
    .txd_i (txd),
    .rxd_o (rxd)
  );

  // the handoff pulse lasts one cycle, so latch it for later checks
  always @(posedge clk) begin
    if (cmd_start === 1'b1) begin
      got_start <= 1'b1;
      got_pw    <= need_pw;
      got_code  <= cmd_code;
    end
  end

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic chk_byte(input string w, input logic [7:0] e,
                          input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic chk_bit(input string w, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %b seen %b", w, e, g);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic expect_byte(input logic [7:0] e);
    logic [7:0] b;
    logic       ok;
    u_prog_ctrl_model.get_byte(b, ok);
    chk_byte("txd byte", e, b);
  endtask

  task automatic expect_quiet();
    repeat (30 * BT) @(posedge clk);
    chk_bit("line quiet", 1'b1, u_prog_ctrl_model.rx_q.size() == 0);
  endtask

  // long settle drains any frame cut short by the reset
  task automatic do_reset();
    @(posedge clk);
    #1 rst_n = 1'b0;
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (12 * BT) @(posedge clk);
    u_prog_ctrl_model.rx_q.delete();
  endtask

  task automatic session();
    do_reset();
    u_prog_ctrl_model.send_byte(MATCH1_A);
    expect_byte(MATCH1_A);
    u_prog_ctrl_model.send_byte(MATCH2_A);
    expect_byte(MATCH2_A);
  endtask

  // f is {erase_pw, debug_sc, sec, erased}
  task automatic status_case(input logic [3:0] f);
    logic [7:0] st;
    st = {4'h0, f[3:1], ~f[0]};
    @(posedge clk);
    #1 {erase_pw, debug_sc, sec, erased} = f;
    repeat (8) @(posedge clk);
    u_prog_ctrl_model.send_byte(CMD_STATUS);
    expect_byte(CMD_STATUS);
    expect_byte(START_MARK);
    expect_byte(BYTE_COUNT);
    expect_byte(st);
    repeat (3) expect_byte(8'h00);
    expect_byte(8'h00 - st);
    chk_byte("status port", st, status_code);
  endtask

  function automatic perm_t exp_perm(input logic [7:0] c,
                                     input logic [2:0] f);
    if (c == CMD_SUM || c == CMD_PRODUCT) return PERM_OK;
    if (c == CMD_ERASE) return (!f[1] && f[0]) ? PERM_PASS : PERM_OK;
    if (c == CMD_SECURITY) return f[1] ? PERM_DENY : PERM_PASS;
    if (f[2]) return PERM_DENY;
    return f[1] ? PERM_OK : PERM_PASS;
  endfunction

  task automatic perm_case(input logic [7:0] c, input logic [2:0] f);
    perm_t p;
    int    n;
    p = exp_perm(c, f);
    session();
    @(posedge clk);
    #1 {sec, erased, erase_pw} = f;
    debug_sc = f[2] ^ f[0];
    got_start = 1'b0;
    repeat (8) @(posedge clk);
    u_prog_ctrl_model.send_byte(c);
    expect_byte(c);
    n = 0;
    while (got_start !== 1'b1 && idle !== 1'b1 && n < 8 * BT) begin
      @(posedge clk);
      n++;
    end
    repeat (2) @(posedge clk);
    chk_bit("handoff", p != PERM_DENY, got_start);
    chk_bit("idle", p == PERM_DENY, idle);
    if (p != PERM_DENY) begin
      chk_bit("password", p == PERM_PASS, got_pw);
      chk_byte("code", c, got_code);
    end
  endtask

  // ************************************************************
  // tests
  // ************************************************************
  // span is about one and a half times the expected run length
  initial begin
    #720000;
    bad_count++;
    stop_test();
  end

  initial begin
    {rst_n, erase_pw, debug_sc, sec, erased} = 5'b00001;
    {bad_count, check_count} = '0;
    got_start = 1'b0;
    do_reset();
    chk_bit("txd at rest", 1'b1, txd);
    chk_bit("idle at rest", 1'b0, idle);
    u_prog_ctrl_model.send_byte(MATCH1_A);
    expect_byte(MATCH1_A);
    u_prog_ctrl_model.send_byte(8'h55);
    expect_quiet();
    u_prog_ctrl_model.send_byte(MATCH2_B);
    expect_byte(MATCH2_B);
    for (int i = 0; i < 16; i += 3) begin
      status_case(i[3:0]);
    end
    session();
    u_prog_ctrl_model.send_byte(8'h55);
    repeat (3) expect_byte(ERR_CODE_C);
    repeat (BT) @(posedge clk);
    chk_bit("idle after error", 1'b1, idle);
    u_prog_ctrl_model.send_byte(CMD_STATUS);
    expect_quiet();
    foreach (fls[j]) begin
      foreach (cmds[k]) begin
        perm_case(cmds[k], fls[j]);
      end
    end
    stop_test();
  end
endmodule

// ### flash_status_pkg.sv
// constants for the serial programming status command interpreter
package flash_status_pkg;
  localparam logic [7:0] MATCH1_A     = 8'h86;
  localparam logic [7:0] MATCH1_B     = 8'h30;
  localparam logic [7:0] MATCH2_A     = 8'h79;
  localparam logic [7:0] MATCH2_B     = 8'hCF;
  localparam logic [7:0] CMD_STATUS   = 8'hC3;
  localparam logic [7:0] CMD_SUM      = 8'h90;
  localparam logic [7:0] CMD_PRODUCT  = 8'hC0;
  localparam logic [7:0] CMD_WRITE    = 8'h30;
  localparam logic [7:0] CMD_READ     = 8'h70;
  localparam logic [7:0] CMD_LOADER   = 8'h60;
  localparam logic [7:0] CMD_ERASE    = 8'hF0;
  localparam logic [7:0] CMD_SECURITY = 8'hFA;
  localparam logic [7:0] ERR_CODE_A   = 8'hA1;
  localparam logic [7:0] ERR_CODE_C   = 8'h63;
  localparam logic [7:0] START_MARK   = 8'h3A;
  localparam logic [7:0] BYTE_COUNT   = 8'h04;
  localparam logic [7:0] RESERVED_VAL = 8'h00;
  localparam logic [7:0] STATUS_MASK  = 8'h0F;
  localparam logic [2:0] ERR_REPEAT   = 3'h3;
  localparam int         BIT_ERASE_PW = 3;
  localparam int         BIT_DEBUG_SC = 2;
  localparam int         BIT_SEC      = 1;
  localparam int         BIT_BLANK    = 0;
  localparam int         SAMPLES_W    = 16;
  localparam logic [7:0] LAST_REPLY   = 8'h06;
  // permission outcomes
  typedef enum logic [1:0] {PERM_OK, PERM_PASS, PERM_DENY} perm_t;
endpackage

// ### prog_ctrl_model.sv
// serial programming controller model: byte sender and reply collector
`timescale 1ns/1ps
module prog_ctrl_model #(
  parameter int BT = 16
) (
  input  wire logic clk_i,
  input  wire logic txd_i,
  output logic      rxd_o
);
  logic [7:0] rx_q[$];
  logic [7:0] sh;

  // line idles high between frames, like the real pin pull-up
  initial rxd_o = 1'b1;

  // ************************************************************
  // sending side
  // ************************************************************
  // every byte, match bytes too, at one fixed bit time
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      #1 rxd_o = fr[i];
      repeat (BT - 1) @(posedge clk_i);
    end
  endtask

  // ************************************************************
  // receiving side
  // ************************************************************
  // runs on its own: the echo starts before our stop bit ends
  always begin
    @(negedge txd_i);
    repeat (BT / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BT) @(posedge clk_i);
      sh[i] = txd_i;
    end
    repeat (BT) @(posedge clk_i);
    rx_q.push_back(sh);
  end

  // a silent device is only revived by reset, never by retrying
  task automatic get_byte(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    while (rx_q.size() == 0 && n < 40 * BT) begin
      @(posedge clk_i);
      n++;
    end
    ok = (rx_q.size() != 0);
    b  = ok ? rx_q.pop_front() : 8'hXX;
  endtask
endmodule

// ### uart_byte_rx.sv
// serial byte receiver with bit-time measured from the first start bit
`timescale 1ns/1ps
module uart_byte_rx
  import flash_status_pkg::*;
#(
  parameter int CW = SAMPLES_W
) (
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          rxd_i,
  output logic               locked_o,
  output logic [CW-1:0]      bit_time_o,
  output logic               byte_valid_o,
  output logic [7:0]         byte_o
);
  typedef enum {S_IDLE, S_MEAS, S_START, S_DATA, S_STOP} rx_state_t;
  rx_state_t        state;
  logic [CW-1:0]    cnt;
  logic [2:0]       bit_idx;
  logic [7:0]       shift;
  logic [1:0]       sync;
  logic             rxd;
  assign rxd = sync[1];
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) sync <= 2'h3;
    else sync <= {sync[0], rxd_i};
  end
  // ******************************************************************
  // first byte: half the low run of start bit plus bit0 defines one bit time
  // ******************************************************************
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state        <= S_IDLE;
      cnt          <= '0;
      bit_idx      <= 3'h0;
      shift        <= 8'h00;
      locked_o     <= 1'b0;
      bit_time_o   <= '0;
      byte_valid_o <= 1'b0;
      byte_o       <= 8'h00;
    end else begin
      byte_valid_o <= 1'b0;
      case (state)
        S_IDLE: begin
          cnt <= '0;
          if (!rxd) state <= locked_o ? S_START : S_MEAS;
        end
        S_MEAS: begin
          cnt <= cnt + 1'b1;
          // low run is start plus bit0 of the first match value, two bits;
          // a first value with a longer low run would mis-measure
          if (rxd) begin
            bit_time_o <= CW'((cnt + 1'b1) >> 1);
            locked_o   <= 1'b1;
            state      <= S_DATA;
            shift      <= 8'h00;
            bit_idx    <= 3'h1;
            // half a bit in, so bits one to seven are sampled mid-bit
            cnt        <= CW'((cnt + 1'b1) >> 2);
          end
        end
        S_START: begin
          cnt <= cnt + 1'b1;
          if (cnt == (bit_time_o >> 1)) begin
            cnt     <= '0;
            bit_idx <= 3'h0;
            state   <= rxd ? S_IDLE : S_DATA;
          end
        end
        S_DATA: begin
          cnt <= cnt + 1'b1;
          if (cnt == bit_time_o - 1'b1) begin
            cnt     <= '0;
            shift   <= {rxd, shift[7:1]};
            bit_idx <= bit_idx + 1'b1;
            if (bit_idx == 3'h7) state <= S_STOP;
          end
        end
        S_STOP: begin
          cnt <= cnt + 1'b1;
          if (cnt == bit_time_o - 1'b1) begin
            byte_o       <= shift;
            byte_valid_o <= rxd;
            state        <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule
